//--- hdl/abpg_map.svh
// constants for the asynchronous bus peripheral glue
`ifndef ABPG_MAP_SVH
`define ABPG_MAP_SVH
// ============================================================
// address decode (word address bits 23:1, local polarity)
`define ABPG_ADDR_W 23
`define ABPG_SEL0_BASE 23'h00_8000
`define ABPG_SEL1_BASE 23'h00_8010
`define ABPG_SEL_MASK 23'h7F_FFF8
// ============================================================
// hold-off timing
`define ABPG_RECOVERY_NS 1750
`define ABPG_CLK_PERIOD_NS 8
`define ABPG_HOLD_CYCLES ((`ABPG_RECOVERY_NS + `ABPG_CLK_PERIOD_NS - 1) / `ABPG_CLK_PERIOD_NS)
`define ABPG_CNT_LOAD 4'h2
`define ABPG_CNT_W 8
// ============================================================
// interrupt acknowledge
`define ABPG_FC_INT_ACK 3'h7
`define ABPG_VECTOR_BASE 8'h40
`define ABPG_VEC_MIN 8'h40
`define ABPG_AUTOVEC_BASE 8'h18
`endif

//--- hdl/abpg_pkg.sv
// types used by the master end of the glue
package abpg_pkg;
  typedef enum logic [1:0] {
    ABPG_IDLE,
    ABPG_ADDR,
    ABPG_STRB,
    ABPG_TERM
  } abpg_mst_state_t;
endpackage

//--- hdl/abpg_if.sv
// processor-side bus between master and glue
`timescale 1ns/1ns
interface abpg_if;
  logic [22:0] addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic read_write;
  logic [2:0] function_code;
  logic address_strobe_n;
  logic upper_byte_strobe_n;
  logic lower_byte_strobe_n;
  logic transfer_ack_n;
  logic autovector_request_n;
  logic [2:0] priority_level_in;
  logic int_ack_cycle_n;
  modport master (
    output addr, wdata, read_write, function_code, address_strobe_n,
    output upper_byte_strobe_n, lower_byte_strobe_n, int_ack_cycle_n,
    input rdata, transfer_ack_n, autovector_request_n, priority_level_in
  );
  modport glue (
    input addr, wdata, read_write, function_code, address_strobe_n,
    input upper_byte_strobe_n, lower_byte_strobe_n, int_ack_cycle_n,
    output rdata, transfer_ack_n, autovector_request_n, priority_level_in
  );
endinterface

//--- hdl/abpg_glue.sv
// glue end: chip selects, hold-off counter, acknowledge, interrupt response
// How it works
// - master drives address S1, strobe S2
// - byte strobes S2 read, S4 write
// - master waits whole clocks without acknowledge
// - strobes drop, then acknowledge drops
// - acknowledge cycle puts level on A1-A3
// - autovector request gives vector 25-31
// - vectored acknowledge drives vector, asserts acknowledge
// - acknowledge-cycle signal decoded from function code
// - seven requests encode to three-bit level
// - supplied vectors come from user range
// - first enable selects character and data registers
// - second enable selects command/status, other address
// - raw selects from address and strobe
// - hold enables 219 clocks after trailing edge
// - recovery covers 600 and 1750 ns
// - hold count follows processor clock rate
// - trailing edge sets inhibit, loads 0010
// - counter runs 219 clocks, drops inhibit
// - inhibit release synchronised forms access allowed
// - enables gated by lower byte strobe only
// - access allowed releases acknowledge on next edge
// - second of double access waits full hold
// - invert read/write, reset, address and data
`timescale 1ns/1ns
`include "abpg_map.svh"
module abpg_glue (
  input wire logic CLOCK,
  input wire logic RST,
  abpg_if.glue BUS,
  input wire logic [6:0] INT_REQUEST_N,
  input wire logic [6:0] INT_VECTORED,
  input wire logic [4:0] VECTOR_UPPER,
  output logic CHECKER_CHAR_ENABLE_N,
  output logic CHECKER_CMD_ENABLE_N,
  output logic PERIPH_READ_N,
  output logic PERIPH_RESET_N,
  output logic [22:0] LOCAL_ADDR,
  output logic [15:0] LOCAL_WDATA,
  input wire logic [15:0] LOCAL_RDATA
);
  // ============================================================
  // address decode
  logic [22:0] local_addr_w;
  logic raw_select0_n;
  logic raw_select1_n;
  logic any_select_n;
  logic int_ack;
  logic [2:0] ack_level;
  assign local_addr_w = ~BUS.addr;
  assign int_ack = (BUS.function_code == `ABPG_FC_INT_ACK) && !BUS.address_strobe_n;
  assign raw_select0_n = !(((local_addr_w & `ABPG_SEL_MASK) == `ABPG_SEL0_BASE)
                           && !BUS.address_strobe_n && !int_ack);
  assign raw_select1_n = !(((local_addr_w & `ABPG_SEL_MASK) == `ABPG_SEL1_BASE)
                           && !BUS.address_strobe_n && !int_ack);
  assign any_select_n = raw_select0_n & raw_select1_n;
  assign ack_level = local_addr_w[2:0];
  // ============================================================
  // hold-off counter
  logic inhibit_ff;
  logic nxt_inhibit;
  logic [`ABPG_CNT_W-1:0] count_ff;
  logic [`ABPG_CNT_W-1:0] nxt_count;
  logic access_allowed_ff;
  logic enable_active_ff;
  logic enables_on;
  logic trailing_edge;
  logic counter_terminal_n;
  localparam logic [`ABPG_CNT_W-1:0] LOAD_V = `ABPG_CNT_W'(`ABPG_CNT_LOAD);
  localparam logic [`ABPG_CNT_W-1:0] END_V = `ABPG_CNT_W'(`ABPG_CNT_LOAD + `ABPG_HOLD_CYCLES - 1);
  assign enables_on = access_allowed_ff && !any_select_n && !BUS.lower_byte_strobe_n;
  assign trailing_edge = enable_active_ff && !enables_on;
  assign counter_terminal_n = !(inhibit_ff && count_ff == END_V);
  always_comb begin
    nxt_inhibit = inhibit_ff;
    nxt_count = count_ff;
    if (trailing_edge) begin
      nxt_inhibit = 1'b1;
      nxt_count = LOAD_V;
    end else if (!counter_terminal_n) begin
      nxt_inhibit = 1'b0;
    end else if (inhibit_ff) begin
      nxt_count = count_ff + `ABPG_CNT_W'(1);
    end
  end
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      inhibit_ff <= 1'b0;
      count_ff <= '0;
      access_allowed_ff <= 1'b1;
      enable_active_ff <= 1'b0;
    end else begin
      inhibit_ff <= nxt_inhibit;
      count_ff <= nxt_count;
      access_allowed_ff <= !nxt_inhibit;
      enable_active_ff <= enables_on;
    end
  end
  // ============================================================
  // chip enables and peripheral side
  assign CHECKER_CHAR_ENABLE_N = !(enables_on && !raw_select0_n);
  assign CHECKER_CMD_ENABLE_N = !(enables_on && !raw_select1_n);
  assign PERIPH_READ_N = !BUS.read_write;
  assign PERIPH_RESET_N = !RST;
  assign LOCAL_ADDR = local_addr_w;
  assign LOCAL_WDATA = ~BUS.wdata;
  // ============================================================
  // interrupt response and acknowledge
  logic req_hit;
  logic vectored_hit;
  logic [7:0] vector_w;
  logic ack_ff;
  logic autovec_ff;
  logic [15:0] rdata_ff;
  logic strobes_off;
  // level encode of the seven requests, highest wins
  always_comb begin
    BUS.priority_level_in = 3'h7;
    for (int i = 0; i < 7; i++) begin
      if (!INT_REQUEST_N[i]) begin
        BUS.priority_level_in = ~3'(i + 1);
      end
    end
  end
  assign req_hit = int_ack && (ack_level != 3'h0) && !INT_REQUEST_N[ack_level - 3'h1];
  assign vectored_hit = req_hit && INT_VECTORED[ack_level - 3'h1];
  assign vector_w = ({VECTOR_UPPER, ack_level} < `ABPG_VEC_MIN)
                    ? (`ABPG_VECTOR_BASE | {5'h00, ack_level})
                    : {VECTOR_UPPER, ack_level};
  assign strobes_off = BUS.address_strobe_n && BUS.lower_byte_strobe_n
                       && BUS.upper_byte_strobe_n;
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      ack_ff <= 1'b0;
      autovec_ff <= 1'b0;
      rdata_ff <= '0;
    end else begin
      if (strobes_off) begin
        ack_ff <= 1'b0;
        autovec_ff <= 1'b0;
      end else begin
        ack_ff <= enables_on || (vectored_hit && !BUS.lower_byte_strobe_n);
        autovec_ff <= req_hit && !vectored_hit;
      end
      if (vectored_hit) begin
        rdata_ff <= ~{8'h00, vector_w};
      end else begin
        rdata_ff <= ~LOCAL_RDATA;
      end
    end
  end
  assign BUS.transfer_ack_n = !ack_ff;
  assign BUS.autovector_request_n = !autovec_ff;
  assign BUS.rdata = rdata_ff;
endmodule

//--- hdl/abpg_master.sv
// master end: simple processor bus cycle sequencer
`timescale 1ns/1ns
`include "abpg_map.svh"
module abpg_master (
  input wire logic CLOCK,
  input wire logic RST,
  abpg_if.master BUS,
  input wire logic REQ,
  input wire logic REQ_READ,
  input wire logic REQ_INT_ACK,
  input wire logic [1:0] REQ_BYTES,
  input wire logic [22:0] REQ_ADDR,
  input wire logic [15:0] REQ_WDATA,
  output logic BUSY,
  output logic DONE,
  output logic [15:0] RDATA,
  output logic [7:0] VECTOR,
  output logic [2:0] PENDING_LEVEL
);
  abpg_pkg::abpg_mst_state_t state_ff;
  abpg_pkg::abpg_mst_state_t nxt_state;
  logic [22:0] addr_ff;
  logic [15:0] wdata_ff;
  logic read_ff;
  logic int_ack_cycle_n_ff;
  logic [1:0] bytes_ff;
  logic [15:0] rdata_ff;
  logic [7:0] vector_ff;
  logic done_ff;
  logic strb_late_ff;
  logic ack_seen;
  assign ack_seen = !BUS.transfer_ack_n || (int_ack_cycle_n_ff && !BUS.autovector_request_n);
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      abpg_pkg::ABPG_IDLE: begin
        if (REQ) begin
          nxt_state = abpg_pkg::ABPG_ADDR;
        end
      end
      abpg_pkg::ABPG_ADDR: begin
        nxt_state = abpg_pkg::ABPG_STRB;
      end
      abpg_pkg::ABPG_STRB: begin
        if (ack_seen) begin
          nxt_state = abpg_pkg::ABPG_TERM;
        end
      end
      abpg_pkg::ABPG_TERM: begin
        if (BUS.transfer_ack_n && BUS.autovector_request_n) begin
          nxt_state = abpg_pkg::ABPG_IDLE;
        end
      end
      default: begin
        nxt_state = abpg_pkg::ABPG_IDLE;
      end
    endcase
  end
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      state_ff <= abpg_pkg::ABPG_IDLE;
      addr_ff <= '0;
      wdata_ff <= '0;
      read_ff <= 1'b1;
      int_ack_cycle_n_ff <= 1'b0;
      bytes_ff <= 2'h0;
      rdata_ff <= '0;
      vector_ff <= '0;
      done_ff <= 1'b0;
      strb_late_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      done_ff <= 1'b0;
      strb_late_ff <= (state_ff == abpg_pkg::ABPG_STRB);
      if (state_ff == abpg_pkg::ABPG_IDLE && REQ) begin
        // acknowledge cycle: level on low bits, rest high
        addr_ff <= REQ_INT_ACK ? {20'hF_FFFF, REQ_ADDR[2:0]} : REQ_ADDR;
        wdata_ff <= REQ_WDATA;
        read_ff <= REQ_READ || REQ_INT_ACK;
        int_ack_cycle_n_ff <= REQ_INT_ACK;
        bytes_ff <= REQ_INT_ACK ? 2'h1 : REQ_BYTES;
      end
      if (state_ff == abpg_pkg::ABPG_STRB && ack_seen) begin
        done_ff <= 1'b1;
        rdata_ff <= ~BUS.rdata;
        if (int_ack_cycle_n_ff && !BUS.autovector_request_n) begin
          vector_ff <= `ABPG_AUTOVEC_BASE + {5'h00, addr_ff[2:0]};
        end else begin
          vector_ff <= ~BUS.rdata[7:0];
        end
      end
    end
  end
  logic strobing;
  logic data_phase;
  assign strobing = (state_ff == abpg_pkg::ABPG_STRB);
  // write strobes wait one clock after the address strobe
  assign data_phase = strobing && (read_ff || strb_late_ff);
  assign BUS.addr = ~addr_ff;
  assign BUS.wdata = ~wdata_ff;
  assign BUS.read_write = read_ff;
  assign BUS.function_code = int_ack_cycle_n_ff ? `ABPG_FC_INT_ACK : 3'h5;
  assign BUS.address_strobe_n = !strobing;
  assign BUS.lower_byte_strobe_n = !(data_phase && bytes_ff[0]);
  assign BUS.upper_byte_strobe_n = !(data_phase && bytes_ff[1]);
  assign BUS.int_ack_cycle_n = !(strobing && int_ack_cycle_n_ff);
  assign BUSY = (state_ff != abpg_pkg::ABPG_IDLE);
  assign DONE = done_ff;
  assign RDATA = rdata_ff;
  assign VECTOR = vector_ff;
  assign PENDING_LEVEL = ~BUS.priority_level_in;
endmodule

//--- tb/abpg_chk.sv
// concurrent checks on the bus between master and glue
`timescale 1ns/1ns
module abpg_chk (
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic [22:0] addr,
  input wire logic read_write,
  input wire logic [2:0] function_code,
  input wire logic address_strobe_n,
  input wire logic upper_byte_strobe_n,
  input wire logic lower_byte_strobe_n,
  input wire logic transfer_ack_n,
  input wire logic autovector_request_n,
  input wire logic int_ack_cycle_n,
  input wire logic CHECKER_CHAR_ENABLE_N,
  input wire logic CHECKER_CMD_ENABLE_N,
  input wire logic PERIPH_READ_N,
  input wire logic [22:0] LOCAL_ADDR
);
  // ============================================================
  // cycles since the last trailing edge of any enable
  logic [9:0] gap_ff;
  wire logic idle_n = CHECKER_CHAR_ENABLE_N & CHECKER_CMD_ENABLE_N;
  wire logic all_up = address_strobe_n & upper_byte_strobe_n & lower_byte_strobe_n;
  always_ff @(posedge CLOCK) begin
    if (RST) gap_ff <= 10'h3FF;
    else if ($rose(idle_n)) gap_ff <= 10'h000;
    else if (gap_ff != 10'h3FF) gap_ff <= gap_ff + 10'h001;
  end
  // ============================================================
  // properties
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RST);
  property p_ack_after_en;
    $fell(idle_n) |=> !transfer_ack_n;
  endproperty
  a_ack_after_en: assert property (p_ack_after_en)
    else $error("no acknowledge after enable");
  property p_en_strobes;
    !idle_n |-> !address_strobe_n && !lower_byte_strobe_n;
  endproperty
  a_en_strobes: assert property (p_en_strobes)
    else $error("enable without strobes");
  property p_en_excl;
    CHECKER_CHAR_ENABLE_N || CHECKER_CMD_ENABLE_N;
  endproperty
  a_en_excl: assert property (p_en_excl)
    else $error("both enables low");
  property p_hold;
    $fell(idle_n) |-> gap_ff >= 10'h0DA;
  endproperty
  a_hold: assert property (p_hold)
    else $error("enable inside hold-off");
  property p_ack_release;
    all_up && !transfer_ack_n |=> transfer_ack_n;
  endproperty
  a_ack_release: assert property (p_ack_release)
    else $error("acknowledge not released");
  property p_ack_cause;
    $fell(transfer_ack_n) |-> !address_strobe_n && ($past(!idle_n) || function_code == 3'h7);
  endproperty
  a_ack_cause: assert property (p_ack_cause)
    else $error("acknowledge without cause");
  property p_autovec;
    $fell(autovector_request_n) |-> function_code == 3'h7 && !address_strobe_n;
  endproperty
  a_autovec: assert property (p_autovec)
    else $error("autovector outside acknowledge cycle");
  property p_int_ack_cycle_n_decode;
    int_ack_cycle_n == !(function_code == 3'h7 && !address_strobe_n);
  endproperty
  a_int_ack_cycle_n_decode: assert property (p_int_ack_cycle_n_decode)
    else $error("acknowledge-cycle signal wrongly decoded");
  property p_invert;
    LOCAL_ADDR == ~addr && PERIPH_READ_N == !read_write;
  endproperty
  a_invert: assert property (p_invert)
    else $error("local lines not inverted");
  c_char: cover property ($fell(CHECKER_CHAR_ENABLE_N));
  c_cmd: cover property ($fell(CHECKER_CMD_ENABLE_N));
  c_auto: cover property ($fell(autovector_request_n));
endmodule

//--- tb/abpg_bench.sv
// self-checking bench joining master and glue
`timescale 1ns/1ns
`include "abpg_map.svh"
module abpg_bench;
  logic CLOCK = 1'b0;
  logic RST = 1'b1;
  logic req, req_read, req_int_ack, busy, done, char_n, cmd_n, prd_n, prst_n;
  logic [1:0] req_bytes;
  logic [22:0] req_addr, laddr;
  logic [15:0] req_wdata, rdata, lwdata, lrdata, seen_w, d;
  logic [7:0] vector, v;
  logic [2:0] pending;
  logic [6:0] int_req_n, int_vec;
  logic [4:0] vec_up;
  logic [17:0] x;
  logic [17:0] exp_q[$];
  int err_count = 0;
  int num_checks = 0;
  always #4 CLOCK = ~CLOCK;
  abpg_if abpg_if_i ();
  abpg_master abpg_master_i (.CLOCK(CLOCK), .RST(RST), .BUS(abpg_if_i.master), .REQ(req),
    .REQ_READ(req_read), .REQ_INT_ACK(req_int_ack), .REQ_BYTES(req_bytes),
    .REQ_ADDR(req_addr), .REQ_WDATA(req_wdata), .BUSY(busy), .DONE(done), .RDATA(rdata),
    .VECTOR(vector), .PENDING_LEVEL(pending));
  abpg_glue abpg_glue_i (.CLOCK(CLOCK), .RST(RST), .BUS(abpg_if_i.glue),
    .INT_REQUEST_N(int_req_n), .INT_VECTORED(int_vec), .VECTOR_UPPER(vec_up),
    .CHECKER_CHAR_ENABLE_N(char_n), .CHECKER_CMD_ENABLE_N(cmd_n), .PERIPH_READ_N(prd_n),
    .PERIPH_RESET_N(prst_n), .LOCAL_ADDR(laddr), .LOCAL_WDATA(lwdata), .LOCAL_RDATA(lrdata));
  abpg_chk abpg_chk_i (.CLOCK(CLOCK), .RST(RST), .addr(abpg_if_i.addr),
    .read_write(abpg_if_i.read_write), .function_code(abpg_if_i.function_code),
    .address_strobe_n(abpg_if_i.address_strobe_n),
    .upper_byte_strobe_n(abpg_if_i.upper_byte_strobe_n),
    .lower_byte_strobe_n(abpg_if_i.lower_byte_strobe_n),
    .transfer_ack_n(abpg_if_i.transfer_ack_n),
    .autovector_request_n(abpg_if_i.autovector_request_n),
    .int_ack_cycle_n(abpg_if_i.int_ack_cycle_n), .CHECKER_CHAR_ENABLE_N(char_n),
    .CHECKER_CMD_ENABLE_N(cmd_n), .PERIPH_READ_N(prd_n), .LOCAL_ADDR(laddr));
  // ============================================================
  // comparison and closing
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_of_test();
    if (err_count == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // ============================================================
  // one bus cycle: wait idle, then request for one clock
  task automatic idle_wait();
    int n;
    n = 0;
    while (busy !== 1'b0 || done !== 1'b0) begin
      @(posedge CLOCK);
      #1;
      n++;
      if (n > 500) begin
        err_count++;
        end_of_test();
      end
    end
  endtask
  task automatic op(input logic [1:0] kind, input logic rd, input logic ia,
                    input logic [1:0] bytes, input logic [22:0] a, input logic [15:0] e);
    idle_wait();
    // peripheral read data only changes once the previous cycle is over
    if (kind == 2'h1) lrdata = e;
    {req_read, req_int_ack, req_bytes, req_addr} = {rd, ia, bytes, a};
    exp_q.push_back({kind, e});
    req = 1'b1;
    @(posedge CLOCK);
    #1;
    req = 1'b0;
  endtask
  // ============================================================
  // result watcher, sampled mid-cycle
  always @(negedge CLOCK) begin
    if (char_n === 1'b0 || cmd_n === 1'b0) seen_w = lwdata;
    if (done === 1'b1 && exp_q.size() > 0) begin
      x = exp_q.pop_front();
      case (x[17:16])
        2'h0: chk(seen_w, x[15:0], "write data");
        2'h1: chk(rdata, x[15:0], "read data");
        default: chk({8'h00, vector}, x[15:0], "vector");
      endcase
    end
  end
  // ============================================================
  // main sequence
  initial begin
    {req, req_read, req_int_ack, req_bytes, req_addr, req_wdata} = '0;
    {int_req_n, int_vec, vec_up, lrdata} = {7'h7F, 7'h00, 5'h00, 16'h0000};
    void'($urandom(32'h0000_8C68));
    repeat (12) @(posedge CLOCK);
    #1;
    chk({15'h0000, prst_n}, 16'h0000, "peripheral reset");
    RST = 1'b0;
    d = 16'($urandom);
    req_wdata = d;
    op(2'h0, 1'b0, 1'b0, 2'h3, `ABPG_SEL0_BASE + 23'h0_0005, d);
    d = 16'($urandom);
    op(2'h1, 1'b1, 1'b0, 2'h1, `ABPG_SEL0_BASE, d);
    d = 16'($urandom);
    op(2'h1, 1'b1, 1'b0, 2'h3, `ABPG_SEL1_BASE + 23'h0_0007, d);
    d = 16'($urandom);
    req_wdata = d;
    op(2'h0, 1'b0, 1'b0, 2'h1, `ABPG_SEL1_BASE, d);
    for (int lv = 1; lv < 8; lv++) begin
      for (int m = 0; m < 2; m++) begin
        // request lines stay put until the previous acknowledge cycle is over
        idle_wait();
        int_req_n = ~(7'h01 << (lv - 1));
        int_vec = m ? 7'h7F : 7'h00;
        vec_up = 5'($urandom);
        v = m ? {vec_up, lv[2:0]} : 8'h18 + {5'h00, lv[2:0]};
        if (m == 1 && v < 8'h40) v = 8'h40 | {5'h00, lv[2:0]};
        @(posedge CLOCK);
        #1;
        chk({13'h0000, pending}, {13'h0000, lv[2:0]}, "pending level");
        op(2'h2, 1'b1, 1'b1, 2'h1, {20'hF_FFFF, lv[2:0]}, {8'h00, v});
      end
    end
    d = 16'($urandom);
    op(2'h1, 1'b1, 1'b0, 2'h1, `ABPG_SEL0_BASE, d);
    // reset in mid-run while the hold-off is running: next access must not wait
    idle_wait();
    RST = 1'b1;
    repeat (2) @(posedge CLOCK);
    #1;
    RST = 1'b0;
    d = 16'($urandom);
    op(2'h1, 1'b1, 1'b0, 2'h1, `ABPG_SEL1_BASE, d);
    repeat (8) @(posedge CLOCK);
    #1;
    chk({15'h0000, busy}, 16'h0000, "busy after reset");
    chk({15'h0000, prst_n}, 16'h0001, "peripheral reset");
    chk(16'(exp_q.size()), 16'h0000, "results outstanding");
    end_of_test();
  end
endmodule
